// ---- hdl/pdt_consts.svh ----
`ifndef PDT_CONSTS_SVH
`define PDT_CONSTS_SVH
`define PDT_ADDR_FBDIV12 8'h3d
`define PDT_ADDR_FBDIV3 8'h3e
`define PDT_ADDR_VCOBIAS 8'h3f
`define PDT_ADDR_PREEMPH 8'h48
`define PDT_ADDR_TRIGCTL 8'h57
`define PDT_RST_FBDIV12 8'h00
`define PDT_RST_FBDIV3 8'h20
`define PDT_RST_VCOBIAS 8'h4f
`define PDT_RST_PREEMPH 8'h00
`define PDT_RST_TRIGCTL 8'h00
`define PDT_MASK_FBDIV12 8'h0f
`define PDT_MASK_FBDIV3 8'h3f
`define PDT_MASK_VCOBIAS 8'h7f
`define PDT_MASK_PREEMPH 8'h0f
`define PDT_MASK_TRIGCTL 8'h87
`define PDT_TRIG_EN_BIT 7
`define PDT_UI16_HALF 7'h08
`define PDT_UI32_HALF 7'h10
`define PDT_UI64_HALF 7'h20
`endif

// ---- hdl/pdt_pkg.sv ----
package pdt_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pdt_bus_s;

    typedef struct packed {
        logic [2:0] first_ratio;
        logic [2:0] second_ratio;
        logic [5:0] third_ratio;
        logic [6:0] osc_bias;
        logic [3:0] preemph;
        logic div_valid;
    } pdt_cfg_s;

    typedef enum logic [1:0] {
        PDT_TRIG_OFF,
        PDT_TRIG_CLK,
        PDT_TRIG_TSTAMP,
        PDT_TRIG_RSVD
    } pdt_trig_e;
endpackage : pdt_pkg

// ---- hdl/pdt_regfile.sv ----
`timescale 1ns/100ps
`include "pdt_consts.svh"
module pdt_regfile
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire pdt_pkg::pdt_bus_s i_bus,
    output logic [7:0] o_rdata,
    output logic [7:0] o_fbdiv12,
    output logic [7:0] o_fbdiv3,
    output logic [7:0] o_vcobias,
    output logic [7:0] o_preemph,
    output logic [7:0] o_trigctl
);
    import pdt_pkg::*;

    // reserved bits are held at zero so they read back as zero
    wire logic [7:0] next_rdata;
    assign next_rdata = (i_bus.addr == `PDT_ADDR_FBDIV12) ? o_fbdiv12 :
                        (i_bus.addr == `PDT_ADDR_FBDIV3) ? o_fbdiv3 :
                        (i_bus.addr == `PDT_ADDR_VCOBIAS) ? o_vcobias :
                        (i_bus.addr == `PDT_ADDR_PREEMPH) ? o_preemph :
                        (i_bus.addr == `PDT_ADDR_TRIGCTL) ? o_trigctl : 8'h00;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_fbdiv12 <= `PDT_RST_FBDIV12;
            o_fbdiv3 <= `PDT_RST_FBDIV3;
            o_vcobias <= `PDT_RST_VCOBIAS;
            o_preemph <= `PDT_RST_PREEMPH;
            o_trigctl <= `PDT_RST_TRIGCTL;
            o_rdata <= 8'h00;
        end
        else
        begin
            if (i_bus.rd)
                o_rdata <= next_rdata;
            if (i_bus.wr && i_bus.addr == `PDT_ADDR_FBDIV12)
                o_fbdiv12 <= i_bus.wdata & `PDT_MASK_FBDIV12;
            if (i_bus.wr && i_bus.addr == `PDT_ADDR_FBDIV3)
                o_fbdiv3 <= i_bus.wdata & `PDT_MASK_FBDIV3;
            if (i_bus.wr && i_bus.addr == `PDT_ADDR_VCOBIAS)
                o_vcobias <= i_bus.wdata & `PDT_MASK_VCOBIAS;
            if (i_bus.wr && i_bus.addr == `PDT_ADDR_PREEMPH)
                o_preemph <= i_bus.wdata & `PDT_MASK_PREEMPH;
            if (i_bus.wr && i_bus.addr == `PDT_ADDR_TRIGCTL)
                o_trigctl <= i_bus.wdata & `PDT_MASK_TRIGCTL;
        end
    end
endmodule : pdt_regfile

// ---- hdl/pdt_top.sv ----
`timescale 1ns/100ps
`include "pdt_consts.svh"
// Function
// - second divider code 0,1,2 gives divide by 1,2,4; code 3 reserved.
// - first divider output feeds second; second output is the sampling clock.
// - first divider code 0,1,2 gives divide by 5,4,3; code 3 reserved.
// - third divider ratio is the six-bit value, 1 to 63, reset 32.
// - sampling clock divided by third ratio gives the feedback clock.
// - one pre-emphasis value drives every lane alike.
// - trigger output buffer and divider run only while enable is 1.
// - modes 0,1,2 output a clock of 16, 32 or 64 unit intervals.
// - mode 3 outputs the resampled timestamp; modes 4 to 7 reserved.
// - clock modes come from the serializer and stop while it re-initializes.
// - enabled trigger clock may serve as the receiver reference clock.
module pdt_top
#(
    parameter int LANES = 8
)
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_SER_UI_TICK,
    input wire logic I_SER_INIT,
    input wire logic I_TIMESTAMP,
    input wire logic I_SYNTH_RESET,
    input wire logic I_SAMPLE_CLK_TICK,
    output logic [7:0] O_RDATA,
    output pdt_pkg::pdt_cfg_s O_CFG,
    output logic [4*LANES-1:0] O_LANE_PREEMPH,
    output logic O_TRIG_OUT_PIN,
    output logic O_TRIG_OUT_OE,
    output logic O_FEEDBACK_CLK
);
    import pdt_pkg::*;

    logic [7:0] fbdiv12;
    logic [7:0] fbdiv3;
    logic [7:0] vcobias;
    logic [7:0] preemph;
    logic [7:0] trigctl;
    pdt_bus_s bus;

    // bus fields travel together so the register file sees one request
    assign bus = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};

    pdt_regfile u_regs
    (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_bus(bus),
        .o_rdata(O_RDATA),
        .o_fbdiv12(fbdiv12),
        .o_fbdiv3(fbdiv3),
        .o_vcobias(vcobias),
        .o_preemph(preemph),
        .o_trigctl(trigctl)
    );

    function automatic logic [2:0] first_ratio(input logic [1:0] code);
        case (code)
            2'h0: first_ratio = 3'h5;
            2'h1: first_ratio = 3'h4;
            2'h2: first_ratio = 3'h3;
            default: first_ratio = 3'h0;
        endcase
    endfunction : first_ratio

    function automatic logic [2:0] second_ratio(input logic [1:0] code);
        case (code)
            2'h0: second_ratio = 3'h1;
            2'h1: second_ratio = 3'h2;
            2'h2: second_ratio = 3'h4;
            default: second_ratio = 3'h0;
        endcase
    endfunction : second_ratio

    // code 3 of either two-bit divider field is reserved
    function automatic logic code_legal(input logic [1:0] code);
        code_legal = (code != 2'h3);
    endfunction : code_legal

    wire logic [5:0] n_ratio;
    assign n_ratio = fbdiv3[5:0];
    wire pdt_cfg_s next_cfg;
    // reserved codes and a zero ratio flag the divider chain as invalid
    assign next_cfg = '{
        first_ratio: first_ratio(fbdiv12[1:0]),
        second_ratio: second_ratio(fbdiv12[3:2]),
        third_ratio: n_ratio,
        osc_bias: vcobias[6:0],
        preemph: preemph[3:0],
        div_valid: code_legal(fbdiv12[1:0]) && code_legal(fbdiv12[3:2]) && (n_ratio != 6'h00)
    };

    wire logic [4*LANES-1:0] next_lane_pe;
    // fanned out here so a lane count change needs no register change
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            assign next_lane_pe[4*g +: 4] = preemph[3:0];
        end
    endgenerate

    // feedback divide of the sampling clock
    logic [5:0] fb_cnt;
    wire logic fb_wrap;
    assign fb_wrap = (fb_cnt >= n_ratio - 6'h01);
    wire logic [5:0] next_fb_cnt;
    assign next_fb_cnt = fb_wrap ? 6'h00 : fb_cnt + 6'h01;
    // odd ratios give a high phase one count shorter than the low phase
    wire logic next_fb_clk;
    assign next_fb_clk = (fb_cnt < (n_ratio >> 1));
    // divider held while synthesizer reset is asserted, so ratio changes take effect cleanly
    wire logic fb_run;
    assign fb_run = !I_SYNTH_RESET && next_cfg.div_valid && I_SAMPLE_CLK_TICK;

    wire logic [6:0] half_ui;
    assign half_ui = (trigctl[1:0] == 2'h0) ? `PDT_UI16_HALF :
                     (trigctl[1:0] == 2'h1) ? `PDT_UI32_HALF : `PDT_UI64_HALF;
    wire logic trig_en;
    assign trig_en = trigctl[`PDT_TRIG_EN_BIT];
    wire pdt_trig_e trig_mode;
    assign trig_mode = !trig_en ? PDT_TRIG_OFF :
                       (trigctl[2:0] <= 3'h2) ? PDT_TRIG_CLK :
                       (trigctl[2:0] == 3'h3) ? PDT_TRIG_TSTAMP : PDT_TRIG_RSVD;
    logic [6:0] ui_cnt;
    logic trig_clk;
    // one resample stage only: the timestamp is taken as synchronous to the clock
    logic tstamp_q;
    wire logic ui_wrap;
    assign ui_wrap = (ui_cnt >= half_ui - 7'h01);
    wire logic [6:0] next_ui_cnt;
    assign next_ui_cnt = ui_wrap ? 7'h00 : ui_cnt + 7'h01;
    // counter restarts from zero, so the first half period after enable is whole
    wire logic ui_hold;
    assign ui_hold = (trig_mode != PDT_TRIG_CLK) || I_SER_INIT;
    logic next_pin;

    // reserved modes and a disabled output both park the pin low
    always_comb
    begin
        case (trig_mode)
            PDT_TRIG_CLK: next_pin = trig_clk;
            PDT_TRIG_TSTAMP: next_pin = tstamp_q;
            default: next_pin = 1'b0;
        endcase
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            fb_cnt <= 6'h00;
            O_FEEDBACK_CLK <= 1'b0;
        end
        else if (fb_run)
        begin
            fb_cnt <= next_fb_cnt;
            O_FEEDBACK_CLK <= next_fb_clk;
        end
        else if (I_SYNTH_RESET)
        begin
            fb_cnt <= 6'h00;
            O_FEEDBACK_CLK <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST || ui_hold)
        begin
            ui_cnt <= 7'h00;
            trig_clk <= 1'b0;
        end
        else if (I_SER_UI_TICK)
        begin
            ui_cnt <= next_ui_cnt;
            if (ui_wrap)
                trig_clk <= !trig_clk;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            tstamp_q <= 1'b0;
            O_TRIG_OUT_PIN <= 1'b0;
            O_TRIG_OUT_OE <= 1'b0;
            O_CFG <= '0;
            O_LANE_PREEMPH <= '0;
        end
        else
        begin
            tstamp_q <= I_TIMESTAMP;
            O_TRIG_OUT_PIN <= next_pin;
            O_TRIG_OUT_OE <= trig_en;
            // registered so consumers see one coherent divider set
            O_CFG <= next_cfg;
            O_LANE_PREEMPH <= next_lane_pe;
        end
    end
endmodule : pdt_top

// ---- dv/pdt_top_chk.sv ----
`timescale 1ns/100ps
module pdt_top_chk
#(
    parameter int LANES = 8
)
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_WR,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_SYNTH_RESET,
    input wire pdt_pkg::pdt_cfg_s O_CFG,
    input wire logic [4*LANES-1:0] O_LANE_PREEMPH,
    input wire logic O_TRIG_OUT_PIN,
    input wire logic O_TRIG_OUT_OE,
    input wire logic O_FEEDBACK_CLK
);
    import pdt_pkg::*;
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    lanes_alike_a:
        assert property (O_LANE_PREEMPH == {LANES{O_LANE_PREEMPH[3:0]}})
        else $error("lanes differ");
    first_code_a:
        assert property (O_CFG.div_valid |-> O_CFG.first_ratio inside {3, 4, 5})
        else $error("first ratio bad");
    second_code_a:
        assert property (O_CFG.div_valid |-> O_CFG.second_ratio inside {1, 2, 4})
        else $error("second ratio bad");
    third_load_a:
        assert property (I_WR && I_ADDR == 8'h3e && I_WDATA[5:0] != 0
            |-> ##2 O_CFG.third_ratio == $past(I_WDATA[5:0], 2))
        else $error("third ratio not loaded");
    preemph_load_a:
        assert property (I_WR && I_ADDR == 8'h48 |-> ##2 O_CFG.preemph == $past(I_WDATA[3:0], 2))
        else $error("preemphasis not loaded");
    trig_enable_a:
        assert property (I_WR && I_ADDR == 8'h57 |-> ##2 O_TRIG_OUT_OE == $past(I_WDATA[7], 2))
        else $error("trigger enable wrong");
    pin_idle_a:
        assert property (!O_TRIG_OUT_OE [*3] |-> !O_TRIG_OUT_PIN)
        else $error("pin active while disabled");
    fb_frozen_a:
        assert property (I_SYNTH_RESET [*4] |-> $stable(O_FEEDBACK_CLK))
        else $error("feedback moves in reset");
endmodule : pdt_top_chk
bind pdt_top pdt_top_chk #(.LANES(LANES)) u_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_WR(I_WR),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_SYNTH_RESET(I_SYNTH_RESET), .O_CFG(O_CFG),
    .O_LANE_PREEMPH(O_LANE_PREEMPH), .O_TRIG_OUT_PIN(O_TRIG_OUT_PIN),
    .O_TRIG_OUT_OE(O_TRIG_OUT_OE), .O_FEEDBACK_CLK(O_FEEDBACK_CLK));

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
    import pdt_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, ts = 0, sr = 1, sinit = 0, fs = 0, p;
    logic tick = 1, half = 0;
    logic [7:0] addr = 0, wd = 0, rdata;
    pdt_cfg_s cfg;
    logic [31:0] lanes;
    logic pin, oe, fb;
    int n_fail = 0, total_checks = 0, cyc = 0;
    wire ms = fs ? fb : pin;
    logic [7:0] ad[5] = '{8'h3d, 8'h3e, 8'h3f, 8'h48, 8'h57};
    logic [7:0] rv[5] = '{8'h00, 8'h20, 8'h4f, 8'h00, 8'h00};
    logic [7:0] mk[5] = '{8'h0f, 8'h3f, 8'h7f, 8'h0f, 8'h87};
    // ticks run every cycle, or every other cycle while half is set
    pdt_top u_dut (.I_CLK(clk), .I_RST(rst), .I_WR(wr), .I_RD(rd), .I_ADDR(addr),
        .I_WDATA(wd), .I_SER_UI_TICK(tick), .I_SER_INIT(sinit), .I_TIMESTAMP(ts),
        .I_SYNTH_RESET(sr), .I_SAMPLE_CLK_TICK(tick), .O_RDATA(rdata), .O_CFG(cfg),
        .O_LANE_PREEMPH(lanes), .O_TRIG_OUT_PIN(pin), .O_TRIG_OUT_OE(oe),
        .O_FEEDBACK_CLK(fb));
    task give_verdict();
        begin
            $display("checks %0d failures %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask : give_verdict
    // returns after the write has reached the outputs
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        begin
            @(posedge clk);
            wr <= 1;
            addr <= a;
            wd <= d;
            @(posedge clk);
            wr <= 0;
            repeat (2) @(posedge clk);
            #1;
        end
    endtask : wr_reg
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        begin
            @(posedge clk);
            rd <= 1;
            addr <= a;
            @(posedge clk);
            rd <= 0;
            #1;
            `CHK("rdata", e, rdata)
        end
    endtask : rd_chk
    // cycles between two rising edges of the selected output
    task per(input int e);
        int n, r, t0;
        begin
            r = 0;
            t0 = 0;
            p = ms;
            for (n = 0; n < 300 && r < 2; n++)
            begin
                @(posedge clk);
                #1;
                if (ms === 1'b1 && p === 1'b0)
                begin
                    r++;
                    if (r == 1)
                        t0 = n;
                end
                p = ms;
            end
            `CHK("period", e, n - 1 - t0)
        end
    endtask : per
    initial
    begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        tick <= half ? ~tick : 1'b1;
        if (cyc == 5000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 5; i++)
            rd_chk(ad[i], rv[i]);
        // reserved bits are dropped and an unmapped place reads zero
        for (int i = 0; i < 5; i++)
        begin
            wr_reg(ad[i], 8'hff);
            rd_chk(ad[i], mk[i]);
        end
        wr_reg(8'h40, 8'h5a);
        rd_chk(8'h40, 8'h00);
        wr_reg(8'h57, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(8'h3d, {4'h0, i[1:0], i[1:0]});
            `CHK("first", 3'(5 - i), cfg.first_ratio)
            `CHK("second", 3'(1 << i), cfg.second_ratio)
        end
        wr_reg(8'h3d, 8'h0f);
        `CHK("valid", 1'b0, cfg.div_valid)
        wr_reg(8'h3d, 8'h06);
        wr_reg(8'h3e, 8'h06);
        `CHK("third", 6'h06, cfg.third_ratio)
        `CHK("valid", 1'b1, cfg.div_valid)
        wr_reg(8'h3f, 8'h4a);
        `CHK("bias", 7'h4a, cfg.osc_bias)
        @(posedge clk);
        sr <= 0;
        fs = 1;
        per(6);
        // ticks on alternate cycles double the period counted in clock cycles
        half = 1;
        repeat (2) @(posedge clk);
        #1;
        per(12);
        half = 0;
        wr_reg(8'h48, 8'h05);
        `CHK("lanes", {8{4'h5}}, lanes)
        `CHK("preemph", 4'h5, cfg.preemph)
        fs = 0;
        for (int m = 0; m < 3; m++)
        begin
            wr_reg(8'h57, 8'h00);
            wr_reg(8'h57, 8'h80 | m[7:0]);
            `CHK("oe", 1'b1, oe)
            per(16 << m);
        end
        wr_reg(8'h57, 8'h00);
        wr_reg(8'h57, 8'h80);
        half = 1;
        repeat (2) @(posedge clk);
        #1;
        per(32);
        half = 0;
        @(posedge clk);
        sinit <= 1;
        repeat (4) @(posedge clk);
        #1;
        `CHK("stopped", 1'b0, pin)
        repeat (40) @(posedge clk);
        #1;
        `CHK("held", 1'b0, pin)
        @(posedge clk);
        sinit <= 0;
        wr_reg(8'h57, 8'h00);
        wr_reg(8'h57, 8'h83);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk);
            ts <= i[1];
            #1;
            if (i > 1)
                `CHK("tstamp", 1'((i - 2) >> 1), pin)
        end
        wr_reg(8'h57, 8'h00);
        wr_reg(8'h57, 8'h85);
        repeat (20) @(posedge clk);
        #1;
        `CHK("reserved", 1'b0, pin)
        give_verdict();
    end
endmodule : testbench
